// file: common/sdcx_pkg.sv
// package for the deep standby clock exit block: register map, field layout, reset values, states.
// assumes a 26-bit AXI4-Lite byte address; register indices are word numbers (byte address = index * 4).
package sdcx_pkg;
    localparam int unsigned AW = 26;
    localparam logic [23:0] IDX_RATIO = 24'hfffdc4;
    localparam logic [23:0] IDX_RESET = 24'hfffe75;
    localparam logic [23:0] IDX_CTRL = 24'hfffe80;
    localparam logic [23:0] IDX_WAKE = 24'hfffe81;
    localparam logic [23:0] IDX_IRQ_ST = 24'hfffe82;
    localparam logic [23:0] IDX_IRQ_MASK = 24'hfffe83;
    localparam logic [AW-1:0] A_RATIO = {IDX_RATIO, 2'h0};
    localparam logic [AW-1:0] A_RESET = {IDX_RESET, 2'h0};
    localparam logic [AW-1:0] A_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [AW-1:0] A_WAKE = {IDX_WAKE, 2'h0};
    localparam logic [AW-1:0] A_IRQ_ST = {IDX_IRQ_ST, 2'h0};
    localparam logic [AW-1:0] A_IRQ_MASK = {IDX_IRQ_MASK, 2'h0};
    // clock_ratio_control fields
    localparam int unsigned RATIO_W = 3;
    localparam int unsigned CPU_RATIO_LSB = 8;
    localparam int unsigned PER_RATIO_LSB = 4;
    localparam logic [15:0] RATIO_RST = 16'h0000;
    // reset_cause_status fields
    localparam int unsigned RST_FLAG_BIT = 7;
    // standby control fields
    localparam int unsigned C_SOFT_SEL = 0;
    localparam int unsigned C_DEEP_SEL = 1;
    localparam int unsigned C_OUT_HOLD = 2;
    localparam int unsigned C_PIN_HOLD = 3;
    localparam int unsigned C_BUS_STOP = 4;
    localparam int unsigned C_SDR_STOP = 5;
    localparam int unsigned C_SELF_REF = 6;
    localparam int unsigned C_CKE_EN = 7;
    localparam int unsigned C_STATE_LSB = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // wake enables: [0] nmi, [4:1] irq pins, [5] timer, [6] usb; edge select 1 = rising
    localparam int unsigned WAKE_EDGE_LSB = 8;
    localparam logic [6:0] WAKE_EN_RST = 7'h00;
    localparam logic [4:0] EDGE_SEL_RST = 5'h00;
    // interrupt status bits
    localparam int unsigned I_SOFT_EXIT = 0;
    localparam int unsigned I_DEEP_EXIT = 1;
    localparam int unsigned I_INT_RESET = 2;
    localparam logic [2:0] IRQ_RST = 3'h0;
    localparam logic CLK_PARK = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_SOFT = 2'h1,
        ST_DEEP = 2'h3,
        ST_WAKE = 2'h2
    } sdcx_state_t;
endpackage : sdcx_pkg

// file: common/sdcx_clk_if.sv
// carrier between the top and one clock output generator.
// assumes both ends run on mclk_i.
`timescale 1ns/1ps
interface sdcx_clk_if;
    logic ref_lvl;
    logic hold;
    logic stop;
    logic clk;
    modport ctl (output ref_lvl, output hold, output stop, input clk);
    modport gen (input ref_lvl, input hold, input stop, output clk);
endinterface : sdcx_clk_if

// file: logic/sdcx_sync2.sv
// two flip-flop synchroniser for pins from outside the mclk_i domain.
// assumes inputs are slow against mclk_i; only the second stage is read.
`timescale 1ns/1ps
module sdcx_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sdcx_sync_t;
    sdcx_sync_t st;
    sdcx_sync_t next_st;

    always_comb begin
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q_o = st.s2;
endmodule : sdcx_sync2

// file: logic/sdcx_clkout.sv
// one gated clock output: follows the sampled reference, parks high on stop, freezes on hold.
// assumes ref_lvl is already synchronised to mclk_i.
`timescale 1ns/1ps
module sdcx_clkout (
    input wire logic mclk_i,
    input wire logic rstn_i,
    sdcx_clk_if.gen cif
);
    typedef struct packed {
        logic clk;
    } sdcx_co_t;
    sdcx_co_t st;
    sdcx_co_t next_st;

    always_comb begin
        next_st = st;
        if (cif.hold) begin
            next_st.clk = st.clk;
        end else if (cif.stop) begin
            next_st.clk = 1'b1;
        end else begin
            // resumes from the parked level, so no partial pulse
            next_st.clk = cif.ref_lvl;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st.clk <= sdcx_pkg::CLK_PARK;
        end else begin
            st <= next_st;
        end
    end

    assign cif.clk = st.clk;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    a_stop_parks_high: assert property ((!cif.hold && cif.stop) |=> cif.clk)
        else $error("stopped clock not parked high");
    a_hold_keeps_level: assert property (cif.hold |=> $stable(cif.clk))
        else $error("held clock changed level");
    a_run_follows_ref: assert property ((!cif.hold && !cif.stop) |=> cif.clk == $past(cif.ref_lvl))
        else $error("running clock does not follow reference");
endmodule : sdcx_clkout

// file: logic/sdcx_top.sv
// deep standby entry/exit sequencer with gated bus and sdram clock outputs and AXI4-Lite registers.
// assumes sleep_i and the timer/usb wake requests come from mclk_i logic; pins are asynchronous.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module sdcx_top (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic [25:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [25:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic sleep_i,
    input wire logic ext_clk_i,
    input wire logic nmi_i,
    input wire logic [3:0] irq_pin_i,
    input wire logic timer_wake_i,
    input wire logic usb_wake_i,
    input wire logic standby_n_i,
    input wire logic [23:0] bus_addr_i,
    input wire logic [3:0] bus_ctrl_i,
    output logic [23:0] bus_addr_o,
    output logic [3:0] bus_ctrl_o,
    output logic bus_oe_o,
    output logic bus_clk_o,
    output logic sdram_clk_o,
    output logic sdram_cke_o,
    output logic sdram_cke_oe_o,
    output logic [2:0] cpu_ratio_o,
    output logic [2:0] periph_ratio_o,
    output logic standby_o,
    output logic int_reset_o,
    output logic irq_o
);
    typedef struct packed {
        sdcx_pkg::sdcx_state_t state;
        logic [15:0] ratio;
        logic [7:0] ctrl;
        logic [6:0] wake_en;
        logic [4:0] edge_sel;
        logic rflag;
        logic rarm;
        logic wake_irq;
        logic [2:0] irq_st;
        logic [2:0] irq_mask;
        logic [4:0] pin_prev;
        logic aw_ok;
        logic [25:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [23:0] bus_addr;
        logic [3:0] bus_ctrl;
        logic bus_oe;
        logic cke;
        logic int_reset;
    } sdcx_st_t;
    sdcx_st_t st;
    sdcx_st_t next_st;

    logic [6:0] pin_s;
    logic ext_clk_s;
    logic [4:0] pin_now;
    logic standby_n_s;
    logic [4:0] edge_hit;
    logic wake_int;
    logic pin_wake;
    logic wake_any;
    logic in_sb;
    logic hold_pins;
    logic rst_clr_ok;
    logic [31:0] rd_data;
    logic rd_err;

    sdcx_clk_if bus_cif ();
    sdcx_clk_if sdr_cif ();

    sdcx_sync2 #(.W(7)) u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .d_i({standby_n_i, ext_clk_i, irq_pin_i, nmi_i}),
        .q_o(pin_s)
    );

    assign pin_now = pin_s[4:0];
    assign ext_clk_s = pin_s[5];
    assign standby_n_s = pin_s[6];

    // per-source edge selection; pins are compared only after the synchroniser
    assign edge_hit = (st.edge_sel & pin_now & ~st.pin_prev) | (~st.edge_sel & ~pin_now & st.pin_prev);
    assign wake_int = |(st.wake_en & {usb_wake_i, timer_wake_i, edge_hit});
    assign pin_wake = !standby_n_s;
    assign wake_any = wake_int || pin_wake;
    assign in_sb = (st.state != sdcx_pkg::ST_RUN);
    assign hold_pins = in_sb || st.ctrl[sdcx_pkg::C_PIN_HOLD];

    // clearing needs a prior read of the flag as 1 and a zero in bit 7
    assign rst_clr_ok = st.aw_ok && st.w_ok && st.awaddr == sdcx_pkg::A_RESET && st.wstrb[0]
        && !st.wdata[sdcx_pkg::RST_FLAG_BIT] && st.rarm;

    // clocks park high through standby, so a pin hold on exit always retains a high level
    assign bus_cif.ref_lvl = ext_clk_s;
    assign bus_cif.hold = st.ctrl[sdcx_pkg::C_PIN_HOLD] && !in_sb;
    assign bus_cif.stop = st.ctrl[sdcx_pkg::C_BUS_STOP] || in_sb;
    assign sdr_cif.ref_lvl = ext_clk_s;
    assign sdr_cif.hold = st.ctrl[sdcx_pkg::C_PIN_HOLD] && !in_sb;
    assign sdr_cif.stop = st.ctrl[sdcx_pkg::C_SDR_STOP] || in_sb;

    sdcx_clkout u_bus_clk (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .cif(bus_cif)
    );

    // same restart procedure, own stop bit
    sdcx_clkout u_sdr_clk (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .cif(sdr_cif)
    );

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (araddr_i)
            sdcx_pkg::A_RATIO: rd_data = {16'h0000, st.ratio};
            sdcx_pkg::A_RESET: rd_data = {24'h00_0000, st.rflag, 7'h00};
            sdcx_pkg::A_CTRL: rd_data = {22'h00_0000, st.state, st.ctrl};
            sdcx_pkg::A_WAKE: rd_data = {19'h0_0000, st.edge_sel, 1'b0, st.wake_en};
            sdcx_pkg::A_IRQ_ST: rd_data = {29'h0000_0000, st.irq_st};
            sdcx_pkg::A_IRQ_MASK: rd_data = {29'h0000_0000, st.irq_mask};
            default: rd_err = 1'b1;
        endcase
    end

    always_comb begin
        logic [2:0] irq_set;
        logic [15:0] wmask;
        irq_set = 3'h0;
        wmask = {{8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
        next_st = st;
        next_st.int_reset = 1'b0;
        next_st.pin_prev = pin_now;

        // write channel: address and data taken in either order
        if (awvalid_i && awready_o) begin
            next_st.aw_ok = 1'b1;
            next_st.awaddr = awaddr_i;
        end
        if (wvalid_i && wready_o) begin
            next_st.w_ok = 1'b1;
            next_st.wdata = wdata_i;
            next_st.wstrb = wstrb_i;
        end
        if (st.bvalid && bready_i) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_ok && st.w_ok) begin
            next_st.aw_ok = 1'b0;
            next_st.w_ok = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = sdcx_pkg::RESP_OKAY;
            case (st.awaddr)
                sdcx_pkg::A_RATIO: begin
                    next_st.ratio = (st.ratio & ~wmask) | (st.wdata[15:0] & wmask);
                end
                sdcx_pkg::A_RESET: begin
                    if (rst_clr_ok) begin
                        next_st.rflag = 1'b0;
                        next_st.rarm = 1'b0;
                    end
                end
                sdcx_pkg::A_CTRL: begin
                    if (st.wstrb[0]) begin
                        next_st.ctrl = st.wdata[7:0];
                    end
                end
                sdcx_pkg::A_WAKE: begin
                    if (st.wstrb[0]) begin
                        next_st.wake_en = st.wdata[6:0];
                    end
                    if (st.wstrb[1]) begin
                        next_st.edge_sel = st.wdata[sdcx_pkg::WAKE_EDGE_LSB +: 5];
                    end
                end
                sdcx_pkg::A_IRQ_ST: begin
                    if (st.wstrb[0]) begin
                        next_st.irq_st = st.irq_st & ~st.wdata[2:0];
                    end
                end
                sdcx_pkg::A_IRQ_MASK: begin
                    if (st.wstrb[0]) begin
                        next_st.irq_mask = st.wdata[2:0];
                    end
                end
                default: next_st.bresp = sdcx_pkg::RESP_SLVERR;
            endcase
        end

        // read channel: one read in flight, answered on the same edge that takes the address
        if (st.rvalid && rready_i) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid_i && arready_o) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_data;
            next_st.rresp = rd_err ? sdcx_pkg::RESP_SLVERR : sdcx_pkg::RESP_OKAY;
            if (araddr_i == sdcx_pkg::A_RESET && st.rflag) begin
                next_st.rarm = 1'b1;
            end
        end

        case (st.state)
            sdcx_pkg::ST_RUN: begin
                if (sleep_i && st.ctrl[sdcx_pkg::C_SOFT_SEL]) begin
                    next_st.state = sdcx_pkg::ST_SOFT;
                end
            end
            sdcx_pkg::ST_SOFT: begin
                // a pending wake source blocks the move into deep standby
                if (wake_any) begin
                    next_st.state = sdcx_pkg::ST_RUN;
                    irq_set[sdcx_pkg::I_SOFT_EXIT] = 1'b1;
                end else if (st.ctrl[sdcx_pkg::C_DEEP_SEL]) begin
                    next_st.state = sdcx_pkg::ST_DEEP;
                end
            end
            sdcx_pkg::ST_DEEP: begin
                if (wake_any) begin
                    next_st.state = sdcx_pkg::ST_WAKE;
                    next_st.wake_irq = wake_int;
                end
            end
            sdcx_pkg::ST_WAKE: begin
                next_st.state = sdcx_pkg::ST_RUN;
                next_st.int_reset = st.wake_irq;
                irq_set[sdcx_pkg::I_DEEP_EXIT] = 1'b1;
                irq_set[sdcx_pkg::I_INT_RESET] = st.wake_irq;
                if (st.wake_irq) begin
                    next_st.rflag = 1'b1;
                end
            end
            default: next_st.state = sdcx_pkg::ST_RUN;
        endcase

        // hardware sets win over the software clears above
        next_st.irq_st = next_st.irq_st | irq_set;

        if (!hold_pins) begin
            next_st.bus_addr = bus_addr_i;
            next_st.bus_ctrl = bus_ctrl_i;
        end
        // without the output hold option the bus floats in standby; an output hold keeps it driven
        next_st.bus_oe = !(in_sb && !st.ctrl[sdcx_pkg::C_OUT_HOLD]);
        next_st.cke = !(in_sb && st.ctrl[sdcx_pkg::C_SELF_REF] && st.ctrl[sdcx_pkg::C_CKE_EN]);
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st <= '0;
            st.state <= sdcx_pkg::ST_RUN;
            st.ratio <= sdcx_pkg::RATIO_RST;
            st.ctrl <= sdcx_pkg::CTRL_RST;
            st.wake_en <= sdcx_pkg::WAKE_EN_RST;
            st.edge_sel <= sdcx_pkg::EDGE_SEL_RST;
            st.irq_st <= sdcx_pkg::IRQ_RST;
            st.irq_mask <= sdcx_pkg::IRQ_RST;
            st.bus_oe <= 1'b1;
            st.cke <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign awready_o = !st.aw_ok && !st.bvalid;
    assign wready_o = !st.w_ok && !st.bvalid;
    assign bvalid_o = st.bvalid;
    assign bresp_o = st.bresp;
    assign arready_o = !st.rvalid;
    assign rvalid_o = st.rvalid;
    assign rdata_o = st.rdata;
    assign rresp_o = st.rresp;
    assign bus_addr_o = st.bus_addr;
    assign bus_ctrl_o = st.bus_ctrl;
    assign bus_oe_o = st.bus_oe;
    assign bus_clk_o = bus_cif.clk;
    assign sdram_clk_o = sdr_cif.clk;
    assign sdram_cke_o = st.cke;
    assign sdram_cke_oe_o = st.ctrl[sdcx_pkg::C_CKE_EN];
    assign cpu_ratio_o = st.ratio[sdcx_pkg::CPU_RATIO_LSB +: sdcx_pkg::RATIO_W];
    assign periph_ratio_o = st.ratio[sdcx_pkg::PER_RATIO_LSB +: sdcx_pkg::RATIO_W];
    assign standby_o = in_sb;
    assign int_reset_o = st.int_reset;
    assign irq_o = |(st.irq_st & st.irq_mask);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_wake_to_run;
        st.state == sdcx_pkg::ST_WAKE ##1 st.state == sdcx_pkg::ST_RUN;
    endsequence
    sequence s_deep_wake;
        st.state == sdcx_pkg::ST_DEEP && wake_any;
    endsequence

    a_soft_entry: assert property ((st.state == sdcx_pkg::ST_RUN && sleep_i && st.ctrl[sdcx_pkg::C_SOFT_SEL])
        |=> st.state == sdcx_pkg::ST_SOFT)
        else $error("sleep did not enter software standby");
    a_deep_entry: assert property ((st.state == sdcx_pkg::ST_SOFT && st.ctrl[sdcx_pkg::C_DEEP_SEL] && !wake_any)
        |=> st.state == sdcx_pkg::ST_DEEP)
        else $error("deep standby not entered");
    a_deep_exit_path: assert property (s_deep_wake |=> s_wake_to_run)
        else $error("deep standby exit sequence wrong");
    a_flag_on_wake: assert property ((s_deep_wake and wake_int) |=> ##1 (st.rflag && int_reset_o))
        else $error("flag or internal reset missing after interrupt wake");
    a_flag_sticks: assert property ((st.rflag && !rst_clr_ok) |=> st.rflag)
        else $error("reset cause flag lost without valid clear");
    a_bus_hold_stable: assert property (hold_pins |=> $stable(bus_addr_o) && $stable(bus_ctrl_o))
        else $error("held bus outputs changed");
    a_bus_drive_hold: assert property ((in_sb && st.ctrl[sdcx_pkg::C_OUT_HOLD]) |=> bus_oe_o)
        else $error("bus released despite output hold");
    a_self_refresh_cke: assert property ((in_sb && st.ctrl[sdcx_pkg::C_SELF_REF] && st.ctrl[sdcx_pkg::C_CKE_EN])
        |=> !sdram_cke_o)
        else $error("cke not low for self-refresh");
endmodule : sdcx_top

// file: tb/sdcx_ext_model.sv
// wake sources and sdram side as seen from outside the block.
// assumes requests come from the bench; pins are asynchronous to mclk_i.
`timescale 1ns/1ps
module sdcx_ext_model (
    input wire logic [3:0] irq_req_i,
    input wire logic nmi_req_i,
    input wire logic standby_pin_req_i,
    input wire logic sdram_cke_i,
    output logic ext_clk_o,
    output logic [3:0] irq_pin_o,
    output logic nmi_o,
    output logic standby_n_o,
    output logic self_refresh_o
);
    // the input clock is the oscillator, so it runs free
    initial begin
        ext_clk_o = 1'b0;
        forever #32 ext_clk_o = ~ext_clk_o;
    end
    // pins lag requests so they never line up with mclk_i
    assign #3 irq_pin_o = irq_req_i;
    assign #3 nmi_o = nmi_req_i;
    assign #3 standby_n_o = ~standby_pin_req_i;
    // memory keeps itself in self-refresh while cke is low
    assign self_refresh_o = ~sdram_cke_i;
endmodule : sdcx_ext_model

// file: tb/deep_standby_clock_exit_test.sv
// self-checking bench: registers, standby entry and exit, clock restart, interrupt.
// assumes sdcx_ext_model supplies the input clock and wake pins.
`timescale 1ns/1ps
module deep_standby_clock_exit_test;
    typedef struct {
        logic [25:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
        logic [2:0] c;
        logic [2:0] p;
    } sdcx_row_t;
    logic mclk_i, rstn_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, sleep_i, timer_wake_i, usb_wake_i;
    logic [25:0] awaddr_i, araddr_i;
    logic [31:0] wdata_i, rdata_o, d;
    logic [3:0] wstrb_i, irq_pin_i, bus_ctrl_i, bus_ctrl_o, irq_req;
    logic [23:0] bus_addr_i, bus_addr_o;
    logic [1:0] bresp_o, rresp_o, r;
    logic [2:0] cpu_ratio_o, periph_ratio_o;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, ext_clk_i, nmi_i, standby_n_i, bus_oe_o;
    logic bus_clk_o, sdram_clk_o, sdram_cke_o, sdram_cke_oe_o, standby_o, int_reset_o, irq_o, nmi_req, standby_pin_req;
    logic sref;
    int mismatches = 0;
    int check_count = 0;
    sdcx_row_t rows[3] = '{
        '{sdcx_pkg::A_RATIO, 32'h10, 32'h10, sdcx_pkg::RESP_OKAY, 3'h0, 3'h1},
        '{sdcx_pkg::A_RATIO, 32'h570, 32'h570, sdcx_pkg::RESP_OKAY, 3'h5, 3'h7},
        '{26'h100, 32'h5a, 32'h0, sdcx_pkg::RESP_SLVERR, 3'h5, 3'h7}};

    sdcx_top DUT (.mclk_i, .rstn_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i,
        .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o,
        .rvalid_o, .rready_i, .sleep_i, .ext_clk_i, .nmi_i, .irq_pin_i, .timer_wake_i, .usb_wake_i,
        .standby_n_i, .bus_addr_i, .bus_ctrl_i, .bus_addr_o, .bus_ctrl_o, .bus_oe_o, .bus_clk_o,
        .sdram_clk_o, .sdram_cke_o, .sdram_cke_oe_o, .cpu_ratio_o, .periph_ratio_o, .standby_o,
        .int_reset_o, .irq_o);
    sdcx_ext_model u_ext (.irq_req_i(irq_req), .nmi_req_i(nmi_req), .standby_pin_req_i(standby_pin_req),
        .sdram_cke_i(sdram_cke_o), .ext_clk_o(ext_clk_i), .irq_pin_o(irq_pin_i), .nmi_o(nmi_i),
        .standby_n_o(standby_n_i), .self_refresh_o(sref));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [25:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        int n;
        @(posedge mclk_i);
        awaddr_i <= a;
        wdata_i <= v;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        bready_i <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge mclk_i);
            ta = awvalid_i & awready_o;
            tw = wvalid_i & wready_o;
            tb = bvalid_o;
            r = bresp_o;
            @(posedge mclk_i);
            if (ta) awvalid_i <= 1'b0;
            if (tw) wvalid_i <= 1'b0;
            if (tb) break;
        end
        bready_i <= 1'b0;
        chk(n < 100, 1'b1);
    endtask : wr

    task automatic rd(input logic [25:0] a);
        logic ta, tr;
        int n;
        @(posedge mclk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        rready_i <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(negedge mclk_i);
            ta = arvalid_i & arready_o;
            tr = rvalid_o;
            d = rdata_o;
            r = rresp_o;
            @(posedge mclk_i);
            if (ta) arvalid_i <= 1'b0;
            if (tr) break;
        end
        rready_i <= 1'b0;
        chk(n < 100, 1'b1);
    endtask : rd

    task automatic rchk(input logic [25:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask : rchk

    // 0 standby low, 1 internal reset pulse, 2 bus clock low, 3 sdram clock low
    task automatic await(input int w, input int lim);
        int n;
        for (n = 0; n < lim; n++) begin
            @(negedge mclk_i);
            if ((w == 0 && standby_o === 1'b0) || (w == 1 && int_reset_o === 1'b1)) break;
            if ((w == 2 && bus_clk_o === 1'b0) || (w == 3 && sdram_clk_o === 1'b0)) break;
        end
        chk(n < lim, 1'b1);
    endtask : await

    task automatic frozen(input int k);
        logic b, s;
        @(negedge mclk_i);
        b = bus_clk_o;
        s = sdram_clk_o;
        repeat (k) begin
            @(negedge mclk_i);
            chk({bus_clk_o, sdram_clk_o}, {b, s});
        end
    endtask : frozen

    // bus inputs move at the sleep edge's successor, so a held output shows the old value
    task automatic slp;
        @(posedge mclk_i);
        sleep_i <= 1'b1;
        @(posedge mclk_i);
        sleep_i <= 1'b0;
        bus_addr_i <= ~bus_addr_i;
        bus_ctrl_i <= ~bus_ctrl_i;
        @(negedge mclk_i);
    endtask : slp

    initial begin
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, sleep_i, timer_wake_i, usb_wake_i} = '0;
        {awaddr_i, araddr_i, wdata_i, irq_req, nmi_req, standby_pin_req} = '0;
        wstrb_i = 4'hf;
        bus_addr_i = 24'h123456;
        bus_ctrl_i = 4'h5;
        rstn_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        rstn_i <= 1'b1;
        repeat (5) @(posedge mclk_i);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(r, rows[i].r);
            rchk(rows[i].a, rows[i].e);
            chk(r, rows[i].r);
            chk({cpu_ratio_o, periph_ratio_o}, {rows[i].c, rows[i].p});
        end
        wr(sdcx_pkg::A_CTRL, 32'h05);
        wr(sdcx_pkg::A_WAKE, 32'h20);
        slp();
        chk(standby_o, 1'b1);
        repeat (3) @(negedge mclk_i);
        chk({bus_addr_o, bus_ctrl_o, bus_oe_o}, {24'h123456, 4'h5, 1'b1});
        rchk(sdcx_pkg::A_CTRL, 32'h105);
        @(posedge mclk_i) timer_wake_i <= 1'b1;
        await(0, 20);
        @(posedge mclk_i) timer_wake_i <= 1'b0;
        wr(sdcx_pkg::A_CTRL, 32'hcb);
        wr(sdcx_pkg::A_WAKE, 32'h202);
        slp();
        repeat (2) @(negedge mclk_i);
        chk({sref, bus_oe_o, sdram_cke_oe_o}, 3'h5);
        rchk(sdcx_pkg::A_CTRL, 32'h3cb);
        frozen(20);
        @(posedge mclk_i) irq_req[0] <= 1'b1;
        await(1, 20);
        chk(standby_o, 1'b0);
        frozen(20);
        wr(sdcx_pkg::A_RESET, 32'h0);
        rchk(sdcx_pkg::A_RESET, 32'h80);
        wr(sdcx_pkg::A_RESET, 32'h80);
        rchk(sdcx_pkg::A_RESET, 32'h80);
        wr(sdcx_pkg::A_RESET, 32'h0);
        rchk(sdcx_pkg::A_RESET, 32'h0);
        wr(sdcx_pkg::A_CTRL, 32'hfb);
        @(negedge mclk_i);
        chk({bus_clk_o, sdram_clk_o}, 2'h3);
        wr(sdcx_pkg::A_CTRL, 32'hf3);
        frozen(20);
        chk({bus_clk_o, sdram_clk_o}, 2'h3);
        wr(sdcx_pkg::A_CTRL, 32'hc3);
        await(2, 40);
        await(3, 40);
        rchk(sdcx_pkg::A_IRQ_ST, 32'h7);
        chk(irq_o, 1'b0);
        wr(sdcx_pkg::A_IRQ_MASK, 32'h2);
        @(negedge mclk_i) chk(irq_o, 1'b1);
        wr(sdcx_pkg::A_IRQ_ST, 32'h7);
        @(negedge mclk_i) chk(irq_o, 1'b0);
        rchk(sdcx_pkg::A_IRQ_ST, 32'h0);
        wr(sdcx_pkg::A_CTRL, 32'h03);
        slp();
        repeat (2) @(negedge mclk_i);
        rchk(sdcx_pkg::A_CTRL, 32'h303);
        @(posedge mclk_i) standby_pin_req <= 1'b1;
        await(0, 20);
        @(posedge mclk_i) standby_pin_req <= 1'b0;
        rchk(sdcx_pkg::A_RESET, 32'h0);
        rchk(sdcx_pkg::A_IRQ_ST, 32'h2);
        @(posedge mclk_i) rstn_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rstn_i <= 1'b1;
        rchk(sdcx_pkg::A_RATIO, 32'h0);
        rchk(sdcx_pkg::A_CTRL, 32'h0);
        chk({bus_oe_o, standby_o}, 2'h2);
        end_sim();
    end

    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule : deep_standby_clock_exit_test
